/* pkg/lic_defs.vh */
`ifndef LIC_DEFS_VH
`define LIC_DEFS_VH
// register byte offsets
`define LIC_OFF_ID 12'h020
`define LIC_OFF_TPR 12'h080
`define LIC_OFF_APR 12'h090
`define LIC_OFF_PPR 12'h0A0
`define LIC_OFF_EOI 12'h0B0
`define LIC_OFF_SVR 12'h0F0
`define LIC_OFF_ICRL 12'h300
`define LIC_OFF_ICRH 12'h310
`define LIC_OFF_TLVT 12'h320
`define LIC_OFF_TINIT 12'h380
`define LIC_OFF_TCUR 12'h390
`define LIC_OFF_TDIV 12'h3E0
`define LIC_OFF_CTRL 12'h400
`define LIC_OFF_XCTL 12'h410
`define LIC_OFF_XLVT 12'h500
// 256-bit arrays: eight words at a 16-byte stride, matched on addr[11:7]
`define LIC_BASE_ISR 5'h02
`define LIC_BASE_TMR 5'h03
`define LIC_BASE_IRR 5'h04
`define LIC_BASE_IER 5'h09
// message types, shared by fabric messages and vector table entries
`define LIC_MT_FIXED 3'h0
`define LIC_MT_LOWEST 3'h1
`define LIC_MT_SMI 3'h2
`define LIC_MT_RREAD 3'h3
`define LIC_MT_NMI 3'h4
`define LIC_MT_INIT 3'h5
`define LIC_MT_START 3'h6
`define LIC_MT_EXTERNAL_PIC_INTERRUPT 3'h7
// non-vectored pulse bit positions
`define LIC_NV_SMI 0
`define LIC_NV_NMI 1
`define LIC_NV_INIT 2
`define LIC_NV_START 3
`define LIC_NV_EXTERNAL_PIC_INTERRUPT 4
// vector table entry fields
`define LIC_LVT_MASK 16
`define LIC_LVT_PERIODIC 17
`define LIC_LVT_LEVEL 15
// reset values and lowest vectored number accepted
`define LIC_RST_LVT 18'h10000
`define LIC_RST_XLVT 17'h10000
`define LIC_RST_SVR 10'h0FF
`define LIC_VEC_FIRST 8'h10
`endif

/* src/lic_top.v */
`timescale 1ns/100ps
`include "lic_defs.vh"
// Summary of operation
// - smi, nmi, init, startup, external_pic_interrupt go straight to the core, never queued
// - fixed or lowest accepted sets request bit of its vector; local uses entry
// - trigger bit set for level, cleared for edge, when request bit is set
// - a repeat of an already pending vector merges into one request
// - vectors 0 to 15 are never accepted as vectored interrupts
// - task and processor priority are 8 bits: main 7-4, sub-class 3-0
// - processor priority is the larger of task main and top in-service main
// - on core take, highest request above processor priority moves to in-service
// - end-of-interrupt write clears highest in-service bit
// - ending a level interrupt broadcasts end-of-interrupt to all controllers
// - with enable capability, a disabled vector is not serviced, stays pending
// - task priority at or above candidate gives spurious vector, no state change
// - fixed and non-vectored messages are accepted without arbitration; remote read is ignored
// - lowest priority goes to the focus while svr bit 9 is clear: vector pending or in service, enabled
// - without focus, arbitration priority is computed, stored, lowest one wins
// - arbitration uses task priority or larger main of request/service vector
// - with enable capability, arbitration vectors come from enabled bits only
// - write to command low launches ipi with command low and high fields
// - initial count write loads current count, decremented per divided tick
// - reaching zero raises timer interrupt unless masked; periodic reloads
// - entry type decode: 000 fixed, 010 smi, 100 nmi, 111 external_pic_interrupt
// - after reset hardware disabled; only smi, nmi, init, external_pic_interrupt accepted
// - init restores reset state except identifier, hardware enable, extended control and extended entries
module lic_top (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // inbound fabric messages, already addressed to this controller
  input wire msg_valid,
  input wire [2:0] msg_type,
  input wire [7:0] msg_vector,
  input wire msg_level,
  input wire msg_arb_win,
  output wire lp_focus,
  output wire [7:0] arb_priority,
  // local interrupt sources for the extended entries
  input wire [3:0] ext_event,
  // core side
  input wire core_take,
  output wire intr_valid,
  output wire [7:0] intr_vector,
  output wire intr_spurious,
  output wire [4:0] nonvec_pulse,
  output wire [7:0] nonvec_vector,
  // outbound fabric
  output wire ipi_valid,
  output wire [31:0] ipi_low,
  output wire [31:0] ipi_high,
  output wire eoi_bcast_valid,
  output wire [7:0] eoi_bcast_vector
);

  function [8:0] lic_hi;
    input [255:0] v;
    integer i;
    begin
      lic_hi = 9'h000;
      for (i = 0; i < 256; i = i + 1)
        if (v[i]) lic_hi = {1'b1, i[7:0]};
    end
  endfunction

  function [255:0] lic_oh;
    input [7:0] v;
    begin
      lic_oh = 256'h1 << v;
    end
  endfunction

  function [4:0] lic_nv;
    input [2:0] t;
    begin
      case (t)
        `LIC_MT_SMI: lic_nv = 5'h01 << `LIC_NV_SMI;
        `LIC_MT_NMI: lic_nv = 5'h01 << `LIC_NV_NMI;
        `LIC_MT_INIT: lic_nv = 5'h01 << `LIC_NV_INIT;
        `LIC_MT_START: lic_nv = 5'h01 << `LIC_NV_START;
        `LIC_MT_EXTERNAL_PIC_INTERRUPT: lic_nv = 5'h01 << `LIC_NV_EXTERNAL_PIC_INTERRUPT;
        default: lic_nv = 5'h00;
      endcase
    end
  endfunction

  reg d_wr_reg, d_rd_reg, rd_done_reg;
  reg [11:0] d_addr_reg;
  reg [31:0] hrdata_reg, rdata;
  reg [7:0] tpr_reg, apr_reg, id_reg;
  reg [9:0] svr_reg;
  reg hw_en_reg, cap_reg;
  reg [31:0] icr_lo_reg, icr_hi_reg, init_reg, cur_reg;
  reg [17:0] tlvt_reg;
  reg [3:0] div_reg;
  reg [7:0] pre_reg;
  reg [16:0] xlvt_reg [0:3];
  reg ipi_reg;
  reg [255:0] irr_reg, isr_reg, tmr_reg, ier_reg;
  reg intr_v_reg, intr_s_reg, eoi_v_reg;
  reg [7:0] intr_vec_reg, nv_vec_reg, eoi_vec_reg;
  reg [4:0] nv_reg;

  // ahb: writes have no wait state; reads take one so read data can be registered in hrdata_reg
  wire a_ph = hsel & htrans[1] & hready;
  wire wr_en = d_wr_reg;
  wire [4:0] a_blk = d_addr_reg[11:7];
  wire [2:0] a_wrd = d_addr_reg[6:4];
  wire a_arr = (d_addr_reg[3:0] == 4'h0);
  assign hreadyout = ~(d_rd_reg & ~rd_done_reg);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_wr_reg <= 1'b0;
      d_rd_reg <= 1'b0;
      rd_done_reg <= 1'b0;
      d_addr_reg <= 12'h000;
      hrdata_reg <= 32'h0;
    end else begin
      if (hready) begin
        d_wr_reg <= a_ph & hwrite;
        d_rd_reg <= a_ph & ~hwrite;
        if (a_ph) d_addr_reg <= haddr[11:0];
      end
      rd_done_reg <= d_rd_reg & ~rd_done_reg;
      if (d_rd_reg & ~rd_done_reg) hrdata_reg <= rdata;
    end
  end

  wire vec_ok = hw_en_reg & svr_reg[8];
  wire [255:0] en_mask = cap_reg ? ier_reg : {256{1'b1}};
  wire [8:0] irr_hi = lic_hi(irr_reg & en_mask);
  wire [8:0] isre_hi = lic_hi(isr_reg & en_mask);
  wire [8:0] isr_top = lic_hi(isr_reg);
  wire [7:0] ppr = (tpr_reg[7:4] >= isr_top[7:4]) ? tpr_reg : {isr_top[7:4], 4'h0};

  // arbitration priority from the enabled request and service vectors
  wire [7:0] apr_next = (tpr_reg[7:4] >= irr_hi[7:4] && tpr_reg[7:4] > isre_hi[7:4]) ? tpr_reg :
                        (irr_hi[7:4] > isre_hi[7:4]) ? {irr_hi[7:4], 4'h0} : {isre_hi[7:4], 4'h0};
  assign arb_priority = apr_reg;

  // focus: svr bit 9 clear, vector already pending or in service, and enabled when capability is on
  assign lp_focus = ~svr_reg[9] & (irr_reg[msg_vector] | isr_reg[msg_vector]) & en_mask[msg_vector];

  wire msg_vec = msg_valid & vec_ok & (msg_vector >= `LIC_VEC_FIRST) &
                 ((msg_type == `LIC_MT_FIXED) |
                  ((msg_type == `LIC_MT_LOWEST) & (lp_focus | msg_arb_win)));
  wire msg_start_ok = (msg_type != `LIC_MT_START) | hw_en_reg;
  wire [4:0] msg_nv = (msg_valid & msg_start_ok) ? lic_nv(msg_type) : 5'h00;
  wire init_now = msg_nv[`LIC_NV_INIT];

  // timer, power-of-two prescaler
  wire [2:0] div_code = {div_reg[3], div_reg[1:0]};
  wire [7:0] div_val = (div_code == 3'h7) ? 8'h01 : (8'h02 << div_code);
  wire tick = (pre_reg >= div_val - 8'h01);
  // firing on the 1 to 0 step lets periodic mode reload in the same tick,
  // so a periodic count never rests at zero where software could read it
  wire t_fire = tick & (cur_reg == 32'h1);

  // local sources: entry 0 is the timer, 1 to 4 the extended entries
  wire [17:0] lvt_w [0:4];
  wire [4:0] fire_w;
  assign lvt_w[0] = {tlvt_reg[17], tlvt_reg[16], 1'b0, tlvt_reg[14:0]};
  assign fire_w[0] = t_fire;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : xent
      // entries sit at a 16-byte stride above the first one
      localparam [11:0] x_off = `LIC_OFF_XLVT + g * 16;
      assign lvt_w[g + 1] = {1'b0, xlvt_reg[g]};
      assign fire_w[g + 1] = ext_event[g];
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          xlvt_reg[g] <= `LIC_RST_XLVT;
        end else if (wr_en && d_addr_reg == x_off) begin
          xlvt_reg[g] <= hwdata[16:0]; // entries survive init
        end
      end
    end
  endgenerate

  reg [255:0] set_m, lvl_m;
  reg [4:0] nv_m;
  integer k;
  always @* begin
    set_m = 256'h0;
    lvl_m = 256'h0;
    nv_m = msg_nv;
    if (msg_vec) begin
      set_m = lic_oh(msg_vector);
      if (msg_level) lvl_m = lic_oh(msg_vector);
    end
    for (k = 0; k < 5; k = k + 1) begin
      if (fire_w[k] && !lvt_w[k][`LIC_LVT_MASK]) begin
        case (lvt_w[k][10:8])
          `LIC_MT_FIXED: begin
            if (vec_ok && lvt_w[k][7:0] >= `LIC_VEC_FIRST) begin
              set_m = set_m | lic_oh(lvt_w[k][7:0]);
              if (lvt_w[k][`LIC_LVT_LEVEL]) lvl_m = lvl_m | lic_oh(lvt_w[k][7:0]);
            end
          end
          `LIC_MT_SMI: nv_m = nv_m | lic_nv(`LIC_MT_SMI);
          `LIC_MT_NMI: nv_m = nv_m | lic_nv(`LIC_MT_NMI);
          `LIC_MT_EXTERNAL_PIC_INTERRUPT: nv_m = nv_m | lic_nv(`LIC_MT_EXTERNAL_PIC_INTERRUPT);
          default: nv_m = nv_m;
        endcase
      end
    end
  end

  // service and end of interrupt
  wire spur = core_take & irr_hi[8] & (tpr_reg[7:4] >= irr_hi[7:4]);
  wire svc = core_take & irr_hi[8] & ~spur & (irr_hi[7:4] > ppr[7:4]);
  wire [255:0] svc_m = svc ? lic_oh(irr_hi[7:0]) : 256'h0;
  wire eoi_do = wr_en & (d_addr_reg == `LIC_OFF_EOI) & isr_top[8];
  wire [255:0] eoi_m = eoi_do ? lic_oh(isr_top[7:0]) : 256'h0;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tpr_reg <= 8'h00;
      svr_reg <= `LIC_RST_SVR;
      hw_en_reg <= 1'b0;
      cap_reg <= 1'b0;
      id_reg <= 8'h00;
      icr_lo_reg <= 32'h0;
      icr_hi_reg <= 32'h0;
      tlvt_reg <= `LIC_RST_LVT;
      init_reg <= 32'h0;
      cur_reg <= 32'h0;
      div_reg <= 4'h0;
      pre_reg <= 8'h00;
      ipi_reg <= 1'b0;
      ier_reg <= {256{1'b1}};
    end else if (init_now) begin
      tpr_reg <= 8'h00;
      svr_reg <= `LIC_RST_SVR;
      icr_lo_reg <= 32'h0;
      icr_hi_reg <= 32'h0;
      tlvt_reg <= `LIC_RST_LVT;
      init_reg <= 32'h0;
      cur_reg <= 32'h0;
      div_reg <= 4'h0;
      pre_reg <= 8'h00;
      ipi_reg <= 1'b0;
      ier_reg <= {256{1'b1}};
    end else begin
      ipi_reg <= wr_en & (d_addr_reg == `LIC_OFF_ICRL);
      pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
      if (tick && cur_reg != 32'h0) begin
        if (cur_reg == 32'h1 && tlvt_reg[`LIC_LVT_PERIODIC]) cur_reg <= init_reg;
        else cur_reg <= cur_reg - 32'h1;
      end
      if (wr_en) begin
        if (a_blk == `LIC_BASE_IER && a_arr) ier_reg[{a_wrd, 5'h00} +: 32] <= hwdata;
        case (d_addr_reg)
          `LIC_OFF_ID: id_reg <= hwdata[31:24];
          `LIC_OFF_TPR: tpr_reg <= hwdata[7:0];
          `LIC_OFF_SVR: svr_reg <= hwdata[9:0];
          `LIC_OFF_ICRL: icr_lo_reg <= hwdata;
          `LIC_OFF_ICRH: icr_hi_reg <= hwdata;
          `LIC_OFF_TLVT: tlvt_reg <= hwdata[17:0];
          `LIC_OFF_TINIT: begin
            init_reg <= hwdata;
            cur_reg <= hwdata;
            pre_reg <= 8'h00;
          end
          `LIC_OFF_TDIV: div_reg <= {hwdata[3], 1'b0, hwdata[1:0]};
          `LIC_OFF_CTRL: hw_en_reg <= hwdata[0];
          `LIC_OFF_XCTL: cap_reg <= hwdata[0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irr_reg <= 256'h0;
      isr_reg <= 256'h0;
      tmr_reg <= 256'h0;
      apr_reg <= 8'h00;
      intr_v_reg <= 1'b0;
      intr_s_reg <= 1'b0;
      intr_vec_reg <= 8'h00;
      nv_reg <= 5'h00;
      nv_vec_reg <= 8'h00;
      eoi_v_reg <= 1'b0;
      eoi_vec_reg <= 8'h00;
    end else if (init_now) begin
      irr_reg <= 256'h0;
      isr_reg <= 256'h0;
      tmr_reg <= 256'h0;
      apr_reg <= 8'h00;
      intr_v_reg <= 1'b0;
      intr_s_reg <= 1'b0;
      nv_reg <= msg_nv;
      nv_vec_reg <= msg_vector;
      eoi_v_reg <= 1'b0;
    end else begin
      // a new arrival beats the service clear of the same vector
      irr_reg <= (irr_reg & ~svc_m) | set_m;
      tmr_reg <= (tmr_reg & ~set_m) | lvl_m;
      isr_reg <= (isr_reg & ~eoi_m) | svc_m;
      apr_reg <= apr_next;
      intr_v_reg <= svc | spur;
      intr_s_reg <= spur;
      if (svc | spur) intr_vec_reg <= spur ? svr_reg[7:0] : irr_hi[7:0];
      nv_reg <= nv_m;
      if (msg_nv[`LIC_NV_START]) nv_vec_reg <= msg_vector;
      eoi_v_reg <= eoi_do & tmr_reg[isr_top[7:0]];
      if (eoi_do) eoi_vec_reg <= isr_top[7:0];
    end
  end

  always @* begin
    rdata = 32'h0;
    case (d_addr_reg)
      `LIC_OFF_ID: rdata = {id_reg, 24'h0};
      `LIC_OFF_TPR: rdata = {24'h0, tpr_reg};
      `LIC_OFF_APR: rdata = {24'h0, apr_reg};
      `LIC_OFF_PPR: rdata = {24'h0, ppr};
      `LIC_OFF_SVR: rdata = {22'h0, svr_reg};
      `LIC_OFF_ICRL: rdata = icr_lo_reg;
      `LIC_OFF_ICRH: rdata = icr_hi_reg;
      `LIC_OFF_TLVT: rdata = {14'h0, tlvt_reg};
      `LIC_OFF_TINIT: rdata = init_reg;
      `LIC_OFF_TCUR: rdata = cur_reg;
      `LIC_OFF_TDIV: rdata = {28'h0, div_reg};
      `LIC_OFF_CTRL: rdata = {31'h0, hw_en_reg};
      `LIC_OFF_XCTL: rdata = {31'h0, cap_reg};
      `LIC_OFF_XLVT: rdata = {15'h0, xlvt_reg[0]};
      `LIC_OFF_XLVT + 12'h010: rdata = {15'h0, xlvt_reg[1]};
      `LIC_OFF_XLVT + 12'h020: rdata = {15'h0, xlvt_reg[2]};
      `LIC_OFF_XLVT + 12'h030: rdata = {15'h0, xlvt_reg[3]};
      default: begin
        if (a_arr && a_blk == `LIC_BASE_ISR) rdata = isr_reg[{a_wrd, 5'h00} +: 32];
        else if (a_arr && a_blk == `LIC_BASE_TMR) rdata = tmr_reg[{a_wrd, 5'h00} +: 32];
        else if (a_arr && a_blk == `LIC_BASE_IRR) rdata = irr_reg[{a_wrd, 5'h00} +: 32];
        else if (a_arr && a_blk == `LIC_BASE_IER) rdata = ier_reg[{a_wrd, 5'h00} +: 32];
        else rdata = 32'h0;
      end
    endcase
  end

  assign intr_valid = intr_v_reg;
  assign intr_vector = intr_vec_reg;
  assign intr_spurious = intr_s_reg;
  assign nonvec_pulse = nv_reg;
  assign nonvec_vector = nv_vec_reg;
  assign ipi_valid = ipi_reg;
  assign ipi_low = icr_lo_reg;
  assign ipi_high = icr_hi_reg;
  assign eoi_bcast_valid = eoi_v_reg;
  assign eoi_bcast_vector = eoi_vec_reg;

endmodule // lic_top

/* sim/lic_core_model.sv */
`timescale 1ns/100ps
module lic_core_model (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // bench control
  input wire ask,
  input wire slow,
  // controller side
  input wire intr_valid,
  input wire [7:0] intr_vector,
  input wire intr_spurious,
  output reg take_reg,
  output reg [7:0] cnt_reg,
  output reg [7:0] vec_reg,
  output reg spur_reg
);
  // a slow core opens its window late, so a pending request must wait
  reg [1:0] dly_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_reg <= 2'h0;
      take_reg <= 1'b0;
      cnt_reg <= 8'h00;
      vec_reg <= 8'h00;
      spur_reg <= 1'b0;
    end else begin
      take_reg <= (dly_reg == 2'h1);
      if (ask)
        dly_reg <= slow ? 2'h3 : 2'h1;
      else if (dly_reg != 2'h0)
        dly_reg <= dly_reg - 2'h1;
      if (intr_valid) begin
        cnt_reg <= cnt_reg + 8'h01;
        vec_reg <= intr_vector;
        spur_reg <= intr_spurious;
      end
    end
  end
endmodule // lic_core_model

/* sim/lic_top_chk.sv */
`timescale 1ns/100ps
`include "lic_defs.vh"
module lic_top_chk (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // messages, core, fabric
  input wire msg_valid,
  input wire [2:0] msg_type,
  input wire core_take,
  input wire intr_valid,
  input wire intr_spurious,
  input wire [4:0] nonvec_pulse,
  input wire ipi_valid,
  input wire eoi_bcast_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire ap = hsel && htrans[1] && hready;
  wire ap_icr = ap && hwrite && haddr[11:0] == `LIC_OFF_ICRL;
  wire ap_eoi = ap && hwrite && haddr[11:0] == `LIC_OFF_EOI;
  sequence rd_sq;
    ap && !hwrite;
  endsequence
  sequence rd_wait_sq;
    !hreadyout ##1 hreadyout;
  endsequence
  bus_okay_a: assert property (hresp == 1'b0) else $error("bad response");
  wr_no_wait_a: assert property (ap && hwrite |=> hreadyout) else $error("write stalled");
  rd_one_wait_a: assert property (rd_sq |=> rd_wait_sq) else $error("read wait wrong");
  smi_direct_a: assert property (msg_valid && msg_type == `LIC_MT_SMI |-> ##[1:2] nonvec_pulse[`LIC_NV_SMI])
    else $error("smi not passed on");
  init_direct_a: assert property (msg_valid && msg_type == `LIC_MT_INIT |-> ##[1:2] nonvec_pulse[`LIC_NV_INIT])
    else $error("init not passed on");
  take_answer_a: assert property (intr_valid |-> $past(core_take)) else $error("unasked delivery");
  spur_deliver_a: assert property (intr_spurious |-> intr_valid) else $error("lone spurious");
  eoi_cause_a: assert property (eoi_bcast_valid |-> $past(ap_eoi, 2) || $past(ap_eoi, 3))
    else $error("broadcast without eoi write");
  ipi_launch_a: assert property (ap_icr |-> ##[2:3] ipi_valid) else $error("ipi not launched");
endmodule // lic_top_chk

bind lic_top lic_top_chk i_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .msg_valid(msg_valid),
  .msg_type(msg_type), .core_take(core_take), .intr_valid(intr_valid), .intr_spurious(intr_spurious),
  .nonvec_pulse(nonvec_pulse), .ipi_valid(ipi_valid), .eoi_bcast_valid(eoi_bcast_valid));

/* sim/lic_top_tb.sv */
`timescale 1ns/100ps
`include "lic_defs.vh"
module lic_top_tb;
  localparam [11:0] MTS = {3'h7, 3'h4, 3'h2, 3'h0};
  reg clk, rst_b, hsel, hwrite, msg_valid, msg_level, msg_arb_win, ask, slow, l;
  reg [31:0] haddr, hwdata, q, d;
  reg [1:0] htrans;
  reg [2:0] msg_type;
  reg [7:0] msg_vector, v, n, bn, bc_n, bc_vec, ipi_n;
  reg [3:0] ext_event;
  reg [4:0] nv_seen;
  wire [31:0] hrdata, ipi_low, ipi_high;
  wire hreadyout, hresp, lp_focus, core_take, intr_valid, intr_spurious, ipi_valid, eoi_bcast_valid, spur;
  wire [7:0] arb_priority, intr_vector, nonvec_vector, eoi_bcast_vector, cnt, vec;
  wire [4:0] nonvec_pulse;
  integer err_count, checks, seed, cyc, i;
  lic_top i_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .msg_valid(msg_valid), .msg_type(msg_type), .msg_vector(msg_vector), .msg_level(msg_level),
    .msg_arb_win(msg_arb_win), .lp_focus(lp_focus), .arb_priority(arb_priority), .ext_event(ext_event),
    .core_take(core_take), .intr_valid(intr_valid), .intr_vector(intr_vector), .intr_spurious(intr_spurious),
    .nonvec_pulse(nonvec_pulse), .nonvec_vector(nonvec_vector), .ipi_valid(ipi_valid), .ipi_low(ipi_low),
    .ipi_high(ipi_high), .eoi_bcast_valid(eoi_bcast_valid), .eoi_bcast_vector(eoi_bcast_vector));
  lic_core_model i_core (.clk(clk), .rst_b(rst_b), .ask(ask), .slow(slow), .intr_valid(intr_valid),
    .intr_vector(intr_vector), .intr_spurious(intr_spurious), .take_reg(core_take), .cnt_reg(cnt),
    .vec_reg(vec), .spur_reg(spur));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    nv_seen <= nv_seen | nonvec_pulse;
    if (eoi_bcast_valid) begin
      bc_n <= bc_n + 8'h01;
      bc_vec <= eoi_bcast_vector;
    end
    if (ipi_valid)
      ipi_n <= ipi_n + 8'h01;
    if (cyc > 20000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  function [11:0] aw(input [4:0] b, input [7:0] vv);
    aw = {b, vv[7:5], 4'h0};
  endfunction
  // ready and read data are taken at the rising edge, before that edge's updates land
  task ahb(input w, input [11:0] a, input [31:0] wd);
    begin
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      if (!w)
        q = hrdata;
    end
  endtask
  task rd_chk(input [11:0] a, input [31:0] e);
    begin
      ahb(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  task send(input [2:0] t, input [7:0] vv, input lv, input w);
    begin
      msg_valid <= 1'b1;
      msg_type <= t;
      msg_vector <= vv;
      msg_level <= lv;
      msg_arb_win <= w;
      @(posedge clk);
      msg_valid <= 1'b0;
      @(posedge clk);
    end
  endtask
  task take;
    begin
      ask <= 1'b1;
      @(posedge clk);
      ask <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  initial begin
    {hsel, hwrite, msg_valid, msg_level, msg_arb_win, ask, slow, haddr, hwdata, htrans} = 0;
    {msg_type, msg_vector, ext_event, nv_seen, bc_n, bc_vec, ipi_n, bn} = 0;
    {err_count, checks, cyc} = 0;
    seed = 2;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(`LIC_OFF_SVR, 32'h000000FF);
    rd_chk(aw(`LIC_BASE_IER, 8'h00), 32'hFFFFFFFF);
    rd_chk(12'h7F0, 32'h0);
    send(`LIC_MT_FIXED, 8'h40, 1'b1, 1'b0);
    rd_chk(aw(`LIC_BASE_IRR, 8'h40), 32'h0);
    send(`LIC_MT_SMI, 8'h00, 1'b0, 1'b0);
    @(posedge clk);
    chk({27'h0, nv_seen}, 32'h1);
    $display("reset state test done");
    ahb(1'b1, `LIC_OFF_CTRL, 32'h1);
    ahb(1'b1, `LIC_OFF_SVR, 32'h1FF);
    send(`LIC_MT_FIXED, 8'h05, 1'b0, 1'b0);
    rd_chk(aw(`LIC_BASE_IRR, 8'h05), 32'h0);
    for (i = 0; i < 5; i = i + 1) begin
      d = $random(seed);
      v = d[7:0];
      if (v[7:4] == 4'h0)
        v[7:4] = 4'h1;
      l = d[8];
      slow <= d[9];
      send(`LIC_MT_FIXED, v, l, 1'b0);
      send(`LIC_MT_FIXED, v, l, 1'b0);
      rd_chk(aw(`LIC_BASE_IRR, v), 32'h1 << v[4:0]);
      // trigger bits of earlier vectors stay, so only this vector's bit is judged
      ahb(1'b0, aw(`LIC_BASE_TMR, v), 32'h0);
      chk(q & (32'h1 << v[4:0]), {31'h0, l} << v[4:0]);
      take;
      chk({24'h0, vec}, {24'h0, v});
      rd_chk(aw(`LIC_BASE_ISR, v), 32'h1 << v[4:0]);
      rd_chk(`LIC_OFF_PPR, {24'h0, v[7:4], 4'h0});
      n = cnt;
      take;
      chk({24'h0, cnt}, {24'h0, n});
      ahb(1'b1, `LIC_OFF_EOI, 32'h0);
      repeat (3) @(posedge clk);
      rd_chk(aw(`LIC_BASE_ISR, v), 32'h0);
      bn = bn + {7'h0, l};
      chk({24'h0, bc_n}, {24'h0, bn});
      if (l)
        chk({24'h0, bc_vec}, {24'h0, v});
    end
    $display("vectored service test done");
    ahb(1'b1, `LIC_OFF_TPR, 32'h80);
    send(`LIC_MT_FIXED, 8'h55, 1'b0, 1'b0);
    take;
    chk({31'h0, spur}, 32'h1);
    chk({24'h0, vec}, 32'hFF);
    rd_chk(aw(`LIC_BASE_ISR, 8'h55), 32'h0);
    ahb(1'b1, `LIC_OFF_TPR, 32'h0);
    ahb(1'b1, `LIC_OFF_XCTL, 32'h1);
    ahb(1'b1, aw(`LIC_BASE_IER, 8'h55), 32'hFFDFFFFF);
    n = cnt;
    take;
    chk({24'h0, cnt}, {24'h0, n});
    rd_chk(aw(`LIC_BASE_IRR, 8'h55), 32'h00200000);
    rd_chk(`LIC_OFF_APR, 32'h0);
    ahb(1'b1, aw(`LIC_BASE_IER, 8'h55), 32'hFFFFFFFF);
    rd_chk(`LIC_OFF_APR, 32'h50);
    chk({24'h0, arb_priority}, 32'h50);
    take;
    chk({24'h0, vec}, 32'h55);
    ahb(1'b1, `LIC_OFF_EOI, 32'h0);
    $display("priority and mask test done");
    send(`LIC_MT_LOWEST, 8'h70, 1'b0, 1'b0);
    rd_chk(aw(`LIC_BASE_IRR, 8'h70), 32'h0);
    send(`LIC_MT_LOWEST, 8'h70, 1'b0, 1'b1);
    rd_chk(aw(`LIC_BASE_IRR, 8'h70), 32'h00010000);
    @(negedge clk);
    chk({31'h0, lp_focus}, 32'h1);
    ahb(1'b1, `LIC_OFF_SVR, 32'h3FF);
    @(negedge clk);
    chk({31'h0, lp_focus}, 32'h0);
    ahb(1'b1, `LIC_OFF_SVR, 32'h1FF);
    d = $random(seed);
    ahb(1'b1, `LIC_OFF_ICRH, d);
    ahb(1'b1, `LIC_OFF_ICRL, ~d);
    repeat (3) @(posedge clk);
    chk(ipi_low, ~d);
    chk(ipi_high, d);
    chk({24'h0, ipi_n}, 32'h1);
    $display("arbitration and command test done");
    ahb(1'b1, `LIC_OFF_TDIV, 32'hB);
    ahb(1'b1, `LIC_OFF_TLVT, 32'h30);
    ahb(1'b1, `LIC_OFF_TINIT, 32'h3);
    repeat (6) @(posedge clk);
    rd_chk(`LIC_OFF_TCUR, 32'h0);
    rd_chk(aw(`LIC_BASE_IRR, 8'h30), 32'h00010000);
    ahb(1'b1, `LIC_OFF_TLVT, 32'h20032);
    ahb(1'b1, `LIC_OFF_TINIT, 32'h4);
    repeat (12) @(posedge clk);
    ahb(1'b0, `LIC_OFF_TCUR, 32'h0);
    chk({31'h0, q != 32'h0}, 32'h1);
    rd_chk(aw(`LIC_BASE_IRR, 8'h30), 32'h00050000);
    ahb(1'b1, `LIC_OFF_TDIV, 32'h0);
    ahb(1'b1, `LIC_OFF_TLVT, 32'h30031);
    ahb(1'b1, `LIC_OFF_TINIT, 32'd100);
    repeat (20) @(posedge clk);
    ahb(1'b0, `LIC_OFF_TCUR, 32'h0);
    chk({31'h0, q > 32'd85 && q < 32'd94}, 32'h1);
    rd_chk(aw(`LIC_BASE_IRR, 8'h30), 32'h00050000);
    $display("timer test done");
    for (i = 0; i < 4; i = i + 1)
      ahb(1'b1, `LIC_OFF_XLVT + i * 16, {21'h0, MTS[i * 3 +: 3], 8'hE8});
    ext_event <= 4'hF;
    @(posedge clk);
    ext_event <= 4'h0;
    repeat (3) @(posedge clk);
    chk({27'h0, nv_seen}, 32'h13);
    rd_chk(aw(`LIC_BASE_IRR, 8'hE8), 32'h100);
    ahb(1'b1, `LIC_OFF_ID, 32'hAB000000);
    ahb(1'b1, `LIC_OFF_TPR, 32'h20);
    send(`LIC_MT_START, 8'h9A, 1'b0, 1'b0);
    chk({24'h0, nonvec_vector}, 32'h9A);
    send(`LIC_MT_RREAD, 8'h60, 1'b0, 1'b0);
    rd_chk(aw(`LIC_BASE_IRR, 8'h60), 32'h00010000);
    send(`LIC_MT_INIT, 8'h00, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk({27'h0, nv_seen}, 32'h1F);
    rd_chk(`LIC_OFF_ID, 32'hAB000000);
    rd_chk(`LIC_OFF_XCTL, 32'h1);
    rd_chk(`LIC_OFF_XLVT, 32'hE8);
    rd_chk(`LIC_OFF_SVR, 32'hFF);
    rd_chk(`LIC_OFF_TPR, 32'h0);
    rd_chk(aw(`LIC_BASE_IRR, 8'h70), 32'h0);
    $display("local entry and init test done");
    stop_test;
  end
endmodule // lic_top_tb
